// [verilog/pfc_pkg.sv]
package pfc_pkg;
    localparam int PFC_PRIO = 8;
    localparam int PFC_QW = 16;
    localparam int PFC_TW = 16;
    // one quantum is 512 bit times
    localparam int PFC_QUANTUM_BITS = 512;
    localparam int PFC_CLK_MHZ = 50;
    // bit rate in Mbit/s of the port
    localparam int PFC_LINK_MBPS = 1000;
    // clock cycles per quantum: 512 bits at 1000 Mbit/s = 512 ns, rounded down
    localparam int PFC_QUANTUM_CYC_RAW =
        (PFC_QUANTUM_BITS * PFC_CLK_MHZ) / PFC_LINK_MBPS;
    localparam int PFC_QUANTUM_CYC = (PFC_QUANTUM_CYC_RAW < 1) ? 1 : PFC_QUANTUM_CYC_RAW;
    localparam logic [PFC_TW-1:0] PFC_TIME_ZERO = 16'h0000;
    localparam logic [PFC_TW-1:0] PFC_TIME_ONE = 16'h0001;
    localparam logic [PFC_PRIO-1:0] PFC_ALL_PRIO = 8'hFF;
    localparam logic [PFC_PRIO-1:0] PFC_NO_PRIO = 8'h00;

    typedef enum logic [2:0] {
        PFC_ST_IDLE = 3'b001,
        PFC_ST_WAIT = 3'b010,
        PFC_ST_SEND = 3'b100
    } pfc_gen_st_t;
endpackage

// [verilog/pfc_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_timer
    import pfc_pkg::*;
(
    input wire logic CLOCK, // core clock
    input wire logic RESET_N, // sync reset
    input wire logic load, // reload strobe
    input wire logic [PFC_TW-1:0] load_val, // quanta to load
    input wire logic tick, // one quantum elapsed
    output logic busy // pause in force
);
    logic [PFC_TW-1:0] count;
    logic [PFC_TW-1:0] next_count;

    assign next_count = load ? load_val :
                        (tick && count != PFC_TIME_ZERO) ? count - PFC_TIME_ONE : count;
    assign busy = (count != PFC_TIME_ZERO);

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            count <= PFC_TIME_ZERO;
        end else begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// [verilog/pfc_wmark.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_wmark
    import pfc_pkg::*;
#(
    parameter int QW = PFC_QW
) (
    input wire logic CLOCK, // core clock
    input wire logic RESET_N, // sync reset
    input wire logic enable, // transmit pause enable
    input wire logic [QW-1:0] depth, // instantaneous queue depth
    input wire logic [QW-1:0] high_mark, // high-water mark
    input wire logic [QW-1:0] low_mark, // low-water mark
    input wire logic frame_rx, // a frame arrived on this queue
    output logic trigger, // pause wanted, one-cycle pulse
    output logic active // between high crossing and low drop
);
    logic above_high;
    logic above_low;
    logic next_active;
    logic rise;

    assign above_high = (depth > high_mark);
    assign above_low = (depth > low_mark);
    assign rise = enable && above_high && !active;
    assign next_active = enable && (rise || (active && above_low));
    assign trigger = rise || (enable && active && above_low && frame_rx);

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            active <= 1'b0;
        end else begin
            active <= next_active;
        end
    end
endmodule
`default_nettype wire

// [verilog/pfc_port.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_port
    import pfc_pkg::*;
#(
    parameter int QW = PFC_QW,
    parameter int NP = PFC_PRIO
) (
    input wire logic CLOCK, // core clock
    input wire logic RESET_N, // sync reset, active low
    input wire logic CFG_PFC_MODE, // 1 priority mode, 0 base pause
    input wire logic CFG_TX_EN, // base mode transmit pause enable
    input wire logic CFG_RX_EN, // base mode receive pause enable
    input wire logic [NP-1:0] CFG_PFC_TX_EN, // per-priority send enable
    input wire logic [NP-1:0] CFG_PFC_RX_EN, // per-priority honour enable
    input wire logic [PFC_TW-1:0] CFG_PAUSE_TIME, // time placed in sent frames
    input wire logic [QW-1:0] CFG_HIGH_MARK, // base high-water mark
    input wire logic [QW-1:0] CFG_LOW_MARK, // base low-water mark
    input wire logic [NP*QW-1:0] CFG_PFC_HIGH_MARK, // per-priority high marks
    input wire logic [NP*QW-1:0] CFG_PFC_LOW_MARK, // per-priority low marks
    input wire logic IS_1G, // port runs at 1 Gbps
    input wire logic LINK_UP, // link status
    input wire logic AN_DONE, // autonegotiation complete pulse
    input wire logic REMOTE_ADV_RX, // partner advertised receive pause
    input wire logic REMOTE_ADV_TX, // partner advertised transmit pause
    input wire logic [QW-1:0] RX_DEPTH, // base queue depth
    input wire logic [NP*QW-1:0] RX_PFC_DEPTH, // per-priority queue depth
    input wire logic RX_FRAME, // frame received pulse
    input wire logic [2:0] RX_FRAME_PRIO, // priority of received frame
    input wire logic RX_PAUSE_VALID, // pause frame processed pulse
    input wire logic RX_PAUSE_IS_PFC, // frame is priority type
    input wire logic [PFC_TW-1:0] RX_PAUSE_TIME, // base frame pause time
    input wire logic [NP-1:0] RX_PFC_MASK, // valid entries mask
    input wire logic [NP*PFC_TW-1:0] RX_PFC_TIMES, // eight pause times
    input wire logic TX_BUSY, // transmitter mid-frame
    input wire logic PAUSE_TX_DONE, // pause frame sent pulse
    output logic ADV_RX, // advertised receive pause
    output logic ADV_TX, // advertised transmit pause
    output logic EFF_TX_EN, // resolved transmit pause enable
    output logic EFF_RX_EN, // resolved receive pause enable
    output logic PAUSE_TX_REQ, // request to send pause frame
    output logic PAUSE_TX_PFC, // pending frame is priority type
    output logic [NP-1:0] PAUSE_TX_MASK, // valid mask for sent frame
    output logic [PFC_TW-1:0] PAUSE_TX_TIME, // time for sent frame
    output logic [NP-1:0] XOFF // per-priority output stall
);
    logic [NP-1:0] wm_trig;
    logic [NP-1:0] wm_act;
    logic base_trig;
    logic base_act;
    logic [NP-1:0] tim_load;
    logic [NP-1:0] tim_busy;
    logic [NP-1:0] pfc_rx_hit;
    logic base_rx_hit;
    logic [NP-1:0] prio_frame;
    logic [$clog2(PFC_QUANTUM_CYC+1)-1:0] qcnt;
    logic quantum_tick;
    logic res_tx;
    logic res_rx;
    logic use_res;
    logic next_use_res;
    logic next_res_tx;
    logic next_res_rx;
    logic [1:0] adv_q;
    logic adv_changed;
    logic [NP-1:0] hold;
    logic [NP-1:0] pend;
    logic [NP-1:0] next_pend;
    logic [NP-1:0] gen_trig;
    pfc_gen_st_t st;
    pfc_gen_st_t next_st;

    function automatic logic [NP-1:0] prio_dec(input logic [2:0] p);
        prio_dec = PFC_NO_PRIO | (8'h01 << p);
    endfunction

    assign ADV_RX = CFG_PFC_MODE ? (|CFG_PFC_RX_EN) : CFG_RX_EN;
    assign ADV_TX = CFG_PFC_MODE ? (|CFG_PFC_TX_EN) : CFG_TX_EN;

    assign next_res_tx = REMOTE_ADV_RX && ADV_TX;
    assign next_res_rx = REMOTE_ADV_TX && ADV_RX;
    assign adv_changed = ({ADV_TX, ADV_RX} != adv_q);
    // enable change on a live 1G link overrides the negotiated result
    assign next_use_res = !LINK_UP ? 1'b0 :
                          (AN_DONE && IS_1G) ? 1'b1 :
                          (adv_changed && IS_1G) ? 1'b0 : use_res;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            res_tx <= 1'b0;
            res_rx <= 1'b0;
            use_res <= 1'b0;
            adv_q <= '0;
        end else begin
            adv_q <= {ADV_TX, ADV_RX};
            use_res <= next_use_res;
            if (AN_DONE) begin
                res_tx <= next_res_tx;
                res_rx <= next_res_rx;
            end
        end
    end

    // link down drops the negotiated result at once
    assign EFF_TX_EN = (use_res && LINK_UP) ? res_tx : ADV_TX;
    assign EFF_RX_EN = (use_res && LINK_UP) ? res_rx : ADV_RX;

    assign quantum_tick = (qcnt == ($clog2(PFC_QUANTUM_CYC+1))'(PFC_QUANTUM_CYC - 1));
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            qcnt <= '0;
        end else begin
            qcnt <= quantum_tick ? '0 : qcnt + 1'b1;
        end
    end

    assign prio_frame = prio_dec(RX_FRAME_PRIO) & {NP{RX_FRAME}};

    pfc_wmark #(.QW(QW)) u_base_wm (
        .CLOCK(CLOCK),
        .RESET_N(RESET_N),
        .enable(!CFG_PFC_MODE && EFF_TX_EN),
        .depth(RX_DEPTH),
        .high_mark(CFG_HIGH_MARK),
        .low_mark(CFG_LOW_MARK),
        .frame_rx(RX_FRAME),
        .trigger(base_trig),
        .active(base_act)
    );

    assign base_rx_hit = RX_PAUSE_VALID && !RX_PAUSE_IS_PFC && !CFG_PFC_MODE && EFF_RX_EN;
    assign pfc_rx_hit = {NP{RX_PAUSE_VALID && RX_PAUSE_IS_PFC && CFG_PFC_MODE && EFF_RX_EN}}
                        & RX_PFC_MASK & CFG_PFC_RX_EN;

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_prio
            pfc_wmark #(.QW(QW)) u_wm (
                .CLOCK(CLOCK),
                .RESET_N(RESET_N),
                .enable(CFG_PFC_MODE && EFF_TX_EN && CFG_PFC_TX_EN[g]),
                .depth(RX_PFC_DEPTH[g*QW +: QW]),
                .high_mark(CFG_PFC_HIGH_MARK[g*QW +: QW]),
                .low_mark(CFG_PFC_LOW_MARK[g*QW +: QW]),
                .frame_rx(prio_frame[g]),
                .trigger(wm_trig[g]),
                .active(wm_act[g])
            );
            // base loads all, priority loads entry g
            assign tim_load[g] = base_rx_hit || pfc_rx_hit[g];
            pfc_timer u_tim (
                .CLOCK(CLOCK),
                .RESET_N(RESET_N),
                .load(tim_load[g]),
                .load_val(base_rx_hit ? RX_PAUSE_TIME : RX_PFC_TIMES[g*PFC_TW +: PFC_TW]),
                .tick(quantum_tick),
                .busy(tim_busy[g])
            );
        end
    endgenerate

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            hold <= PFC_NO_PRIO;
        end else begin
            hold <= TX_BUSY ? (hold & tim_busy) : tim_busy;
        end
    end
    assign XOFF = hold;

    // pause frame generation
    assign gen_trig = CFG_PFC_MODE ? wm_trig : (base_trig ? PFC_ALL_PRIO : PFC_NO_PRIO);
    assign next_pend = (st == PFC_ST_SEND && PAUSE_TX_DONE) ? gen_trig : (pend | gen_trig);

    always_comb begin
        next_st = st;
        case (st)
            PFC_ST_IDLE: begin
                if (|gen_trig) begin
                    next_st = PFC_ST_WAIT;
                end
            end
            PFC_ST_WAIT: begin
                next_st = PFC_ST_SEND;
            end
            PFC_ST_SEND: begin
                if (PAUSE_TX_DONE) begin
                    next_st = (|gen_trig) ? PFC_ST_WAIT : PFC_ST_IDLE;
                end
            end
            default: begin
                next_st = PFC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            st <= PFC_ST_IDLE;
            pend <= PFC_NO_PRIO;
            PAUSE_TX_MASK <= PFC_NO_PRIO;
            PAUSE_TX_TIME <= PFC_TIME_ZERO;
            PAUSE_TX_PFC <= 1'b0;
        end else begin
            st <= next_st;
            pend <= next_pend;
            if (st == PFC_ST_WAIT) begin
                PAUSE_TX_TIME <= CFG_PAUSE_TIME;
                PAUSE_TX_MASK <= CFG_PFC_MODE ? pend : PFC_NO_PRIO;
                PAUSE_TX_PFC <= CFG_PFC_MODE;
            end
        end
    end

    assign PAUSE_TX_REQ = (st == PFC_ST_SEND);
endmodule
`default_nettype wire

// [testbench/pfc_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_port_assertions
    import pfc_pkg::*;
#(
    parameter int NP = PFC_PRIO
) (
    input wire logic CLOCK, // clock
    input wire logic RESET_N, // reset
    input wire logic CFG_PFC_MODE, // mode
    input wire logic CFG_TX_EN, // tx en
    input wire logic CFG_RX_EN, // rx en
    input wire logic [NP-1:0] CFG_PFC_RX_EN, // honour en
    input wire logic [PFC_TW-1:0] CFG_PAUSE_TIME, // sent time
    input wire logic IS_1G, // speed
    input wire logic LINK_UP, // link
    input wire logic AN_DONE, // an done
    input wire logic REMOTE_ADV_RX, // far rx
    input wire logic REMOTE_ADV_TX, // far tx
    input wire logic RX_PAUSE_VALID, // pause in
    input wire logic RX_PAUSE_IS_PFC, // type
    input wire logic [PFC_TW-1:0] RX_PAUSE_TIME, // time in
    input wire logic TX_BUSY, // mid-frame
    input wire logic PAUSE_TX_DONE, // sent
    input wire logic ADV_RX, // adv rx
    input wire logic ADV_TX, // adv tx
    input wire logic EFF_TX_EN, // eff tx
    input wire logic EFF_RX_EN, // eff rx
    input wire logic PAUSE_TX_REQ, // request
    input wire logic PAUSE_TX_PFC, // type out
    input wire logic [NP-1:0] PAUSE_TX_MASK, // mask out
    input wire logic [PFC_TW-1:0] PAUSE_TX_TIME, // time out
    input wire logic [NP-1:0] XOFF // stall
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    sequence base_pause_s;
        RX_PAUSE_VALID && !RX_PAUSE_IS_PFC && !CFG_PFC_MODE && EFF_RX_EN && !TX_BUSY
            && RX_PAUSE_TIME != PFC_TIME_ZERO;
    endsequence
    sequence an_done_s;
        AN_DONE && IS_1G && LINK_UP;
    endsequence
    req_hold_a: assert property (
        PAUSE_TX_REQ && !PAUSE_TX_DONE |=> PAUSE_TX_REQ) else $error("request dropped");
    time_shared_a: assert property (
        PAUSE_TX_REQ |-> PAUSE_TX_TIME == CFG_PAUSE_TIME) else $error("sent time wrong");
    base_mask_a: assert property (
        PAUSE_TX_REQ && !PAUSE_TX_PFC |-> PAUSE_TX_MASK == 8'h00) else $error("base mask set");
    base_all_a: assert property (
        !CFG_PFC_MODE |-> XOFF == 8'h00 || XOFF == 8'hFF) else $error("base stall partial");
    busy_defer_a: assert property (
        (XOFF & ~$past(XOFF)) != 8'h00 |-> !$past(TX_BUSY)) else $error("stall mid-frame");
    rx_load_a: assert property (
        base_pause_s |-> ##[1:3] XOFF == 8'hFF) else $error("pause not honoured");
    prio_gate_a: assert property (
        CFG_PFC_MODE |-> (XOFF & ~$past(XOFF) & ~CFG_PFC_RX_EN) == 8'h00)
        else $error("disabled priority stalled");
    eff_link_a: assert property (
        !LINK_UP && !CFG_PFC_MODE |-> EFF_TX_EN == CFG_TX_EN && EFF_RX_EN == CFG_RX_EN)
        else $error("enables not config");
    resolve_a: assert property (
        an_done_s |=> EFF_TX_EN == ($past(ADV_TX) & $past(REMOTE_ADV_RX))
        && EFF_RX_EN == ($past(ADV_RX) & $past(REMOTE_ADV_TX))) else $error("bad resolution");
endmodule
bind pfc_port pfc_port_assertions #(.NP(NP)) u_pfc_port_assertions (.*);
`default_nettype wire

// [testbench/pfc_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pfc_mac_model (
    input wire logic CLOCK, // core clock
    input wire logic RESET_N, // sync reset
    input wire logic PAUSE_TX_REQ, // frame wanted
    input wire logic [3:0] dly, // cycles to send
    output logic PAUSE_TX_DONE, // sent pulse
    output logic [7:0] n_sent // frames sent
);
    logic [3:0] cnt;
    always_ff @(posedge CLOCK) begin
        PAUSE_TX_DONE <= 1'h0;
        if (!RESET_N || !PAUSE_TX_REQ || PAUSE_TX_DONE) begin
            cnt <= 4'h0;
        end else if (cnt == dly) begin
            PAUSE_TX_DONE <= 1'h1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            n_sent <= 8'h00;
        end else if (PAUSE_TX_DONE) begin
            n_sent <= n_sent + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [testbench/pfc_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module pfc_port_bench
    import pfc_pkg::*;
;
    logic CLOCK = 1'h0, RESET_N = 1'h0;
    logic CFG_PFC_MODE, CFG_TX_EN, CFG_RX_EN, IS_1G, LINK_UP, AN_DONE, REMOTE_ADV_RX;
    logic REMOTE_ADV_TX, RX_FRAME, RX_PAUSE_VALID, RX_PAUSE_IS_PFC, TX_BUSY, PAUSE_TX_DONE;
    logic ADV_RX, ADV_TX, EFF_TX_EN, EFF_RX_EN, PAUSE_TX_REQ, PAUSE_TX_PFC;
    logic [2:0] RX_FRAME_PRIO;
    logic [3:0] mac_dly;
    logic [7:0] CFG_PFC_TX_EN, CFG_PFC_RX_EN, RX_PFC_MASK, PAUSE_TX_MASK, XOFF, n_sent;
    logic [15:0] CFG_PAUSE_TIME, CFG_HIGH_MARK, CFG_LOW_MARK, RX_DEPTH, RX_PAUSE_TIME;
    logic [15:0] PAUSE_TX_TIME;
    logic [127:0] CFG_PFC_HIGH_MARK, CFG_PFC_LOW_MARK, RX_PFC_DEPTH, RX_PFC_TIMES;
    int err_total = 0, n_compared = 0;
    always #10 CLOCK = ~CLOCK;
    pfc_port u_pfc_port (.*);
    pfc_mac_model u_pfc_mac_model (.CLOCK(CLOCK), .RESET_N(RESET_N), .PAUSE_TX_REQ(PAUSE_TX_REQ),
        .dly(mac_dly), .PAUSE_TX_DONE(PAUSE_TX_DONE), .n_sent(n_sent));
    task automatic cyc(input int n);
        repeat (n) @(negedge CLOCK);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_until(input logic req, output int n);
        for (n = 0; n < 200 && (req ? PAUSE_TX_REQ !== 1'h1 : XOFF !== 8'h00); n++) cyc(1);
        if (n == 200) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic send_pause(input logic pfc, input logic [15:0] t, input logic [7:0] m);
        RX_PAUSE_IS_PFC = pfc;
        RX_PAUSE_TIME = t;
        RX_PFC_MASK = m;
        RX_PFC_TIMES = {8{t}};
        RX_PAUSE_VALID = 1'h1;
        cyc(1);
        RX_PAUSE_VALID = 1'h0;
        cyc(3);
    endtask
    task automatic frame();
        RX_FRAME = 1'h1;
        cyc(1);
        RX_FRAME = 1'h0;
        cyc(10);
    endtask
    task automatic t_base_gen();
        int n;
        RX_DEPTH = 16'h0011;
        cyc(10);
        `CHK(n_sent, 8'h00)
        RX_DEPTH = 16'h0000;
        CFG_TX_EN = 1'h1;
        cyc(2);
        RX_DEPTH = 16'h0011;
        wait_until(1'h1, n);
        `CHK(PAUSE_TX_TIME, 16'h0040)
        cyc(10);
        `CHK(n_sent, 8'h01)
        RX_DEPTH = 16'h0009;
        frame();
        `CHK(n_sent, 8'h02)
        RX_DEPTH = 16'h0004;
        frame();
        `CHK(n_sent, 8'h02)
        $display("t_base_gen done");
    endtask
    task automatic t_base_rx();
        int n;
        CFG_RX_EN = 1'h1;
        TX_BUSY = 1'h1;
        send_pause(1'h0, 16'h0002, 8'h00);
        `CHK(XOFF, 8'h00)
        TX_BUSY = 1'h0;
        cyc(3);
        `CHK(XOFF, 8'hFF)
        wait_until(1'h0, n);
        `CHK(n > 16 && n < 48, 1'h1)
        send_pause(1'h0, 16'h0004, 8'h00);
        `CHK(XOFF, 8'hFF)
        send_pause(1'h0, PFC_TIME_ZERO, 8'h00);
        `CHK(XOFF, 8'h00)
        CFG_RX_EN = 1'h0;
        send_pause(1'h0, 16'h0004, 8'h00);
        `CHK(XOFF, 8'h00)
        $display("t_base_rx done");
    endtask
    task automatic t_pfc();
        int n;
        CFG_PFC_MODE = 1'h1;
        CFG_PFC_RX_EN = 8'hDF;
        mac_dly = 4'hA;
        send_pause(1'h0, 16'h0004, 8'h00);
        `CHK(XOFF, 8'h00)
        send_pause(1'h1, 16'h0003, 8'h29);
        `CHK(XOFF, 8'h09)
        wait_until(1'h0, n);
        CFG_PFC_TX_EN = 8'h04;
        CFG_PAUSE_TIME = 16'h0123;
        RX_PFC_DEPTH[63:32] = {2{16'h0011}};
        wait_until(1'h1, n);
        `CHK(PAUSE_TX_PFC, 1'h1)
        `CHK(PAUSE_TX_MASK, 8'h04)
        `CHK(PAUSE_TX_TIME, 16'h0123)
        RX_PFC_DEPTH = '0;
        cyc(30);
        CFG_PFC_MODE = 1'h0;
        $display("t_pfc done");
    endtask
    task automatic t_autoneg();
        logic [5:0] tbl [4] = '{6'h2E, 6'h39, 6'h3F, 6'h30};
        for (int i = 0; i < 4; i++) begin
            LINK_UP = 1'h0;
            {CFG_TX_EN, CFG_RX_EN, REMOTE_ADV_TX, REMOTE_ADV_RX} = tbl[i][5:2];
            cyc(2);
            LINK_UP = 1'h1;
            AN_DONE = 1'h1;
            cyc(1);
            AN_DONE = 1'h0;
            `CHK({ADV_TX, ADV_RX}, tbl[i][5:4])
            `CHK({EFF_TX_EN, EFF_RX_EN}, tbl[i][1:0])
            cyc(3);
            `CHK({EFF_TX_EN, EFF_RX_EN}, tbl[i][1:0])
            CFG_TX_EN = ~CFG_TX_EN;
            cyc(3);
            `CHK({EFF_TX_EN, EFF_RX_EN}, {~tbl[i][5], tbl[i][4]})
        end
        $display("t_autoneg done");
    endtask
    initial begin
        {CFG_PFC_MODE, CFG_TX_EN, CFG_RX_EN, LINK_UP, AN_DONE, REMOTE_ADV_RX} = '0;
        {REMOTE_ADV_TX, RX_FRAME, RX_PAUSE_VALID, RX_PAUSE_IS_PFC, TX_BUSY, RX_FRAME_PRIO} = '0;
        {CFG_PFC_TX_EN, CFG_PFC_RX_EN, RX_PFC_MASK, RX_DEPTH, RX_PAUSE_TIME} = '0;
        {RX_PFC_DEPTH, RX_PFC_TIMES} = '0;
        CFG_PAUSE_TIME = 16'h0040;
        CFG_HIGH_MARK = 16'h0010;
        CFG_LOW_MARK = 16'h0008;
        CFG_PFC_HIGH_MARK = {8{16'h0010}};
        CFG_PFC_LOW_MARK = {8{16'h0008}};
        IS_1G = 1'h1;
        mac_dly = 4'h1;
        cyc(8);
        RESET_N = 1'h1;
        cyc(1);
        `CHK({XOFF, PAUSE_TX_REQ}, 9'h000)
        t_base_gen();
        t_base_rx();
        t_pfc();
        t_autoneg();
        give_verdict();
    end
endmodule
`default_nettype wire
